// >>> pdmm_top.sv
`timescale 1ns/100ps
module pdmm_top
    import pdmm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // core program side
    input  wire logic        fetch_i,
    input  wire logic        irq_take_i,
    output logic      [12:0] pc_o,
    output logic      [12:0] pmem_addr_o,
    // core status view
    output logic             bank_o
);
    typedef enum logic [1:0] {
        PDMM_IDLE = 2'b00,
        PDMM_READ = 2'b01,
        PDMM_ACK  = 2'b10
    } pdmm_state_e;

    pdmm_ram_if ram ();

    pdmm_state_e st_r, st_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic        ack_r, ack_nxt;
    logic [12:0] pc_r, pc_nxt;
    logic [12:0] pma_r, pma_nxt;
    logic [7:0]  status_r, status_nxt;
    logic [7:0]  ptr_r, ptr_nxt;
    logic [7:0]  program_counter_high_holding_r, program_counter_high_holding_nxt;
    logic [7:0]  intctl_r, intctl_nxt;
    logic        large_r, large_nxt;
    logic        rd_ram_r, rd_ram_nxt;
    logic [7:0]  idx;
    logic [7:0]  faddr;
    logic        bank;
    logic [6:0]  off;
    logic        is_ram;
    logic [6:0]  ram_addr;
    logic        wr_lane0;
    logic [12:0] pmask;

    pdmm_ram u_ram (
        .clk_i (clk_i),
        .port  (ram.slave)
    );

    // address decode: the index selects a data file location
    always_comb begin
        idx = adr_i[9:2];
        if (idx == IDX_INDIRECT) begin
            faddr = ptr_r;
        end else begin
            faddr = idx;
        end
        if (idx == IDX_INDIRECT) begin
            bank = faddr[7];
        end else begin
            bank = status_r[ST_BANK];
        end
        off = faddr[6:0];
    end

    // bank 1 storage starts just above the special slots
    localparam logic [6:0] B1_BASE = SFR_TOP + 7'h01;

    // storage map decode; only the two own register indices are kept off the file
    always_comb begin
        is_ram   = 1'b0;
        ram_addr = off;
        if (off > SFR_TOP && idx != IDX_CONFIG && idx != IDX_FETCH) begin
            if (off >= COMMON_LO) begin
                is_ram = 1'b1;
            end else if (large_r) begin
                is_ram = 1'b1;
                if (bank) begin
                    // lower bank 1 slots land in the words bank 0 leaves free;
                    // upper bank 1 slots share words with lower bank 0 ones
                    is_ram   = (off <= LARGE_B1_HI);
                    ram_addr = off - B1_BASE;
                end
            end else if (!bank && off >= SMALL_GP_LO) begin
                is_ram = 1'b1;
            end
        end
    end

    assign wr_lane0 = cyc_i && stb_i && we_i && sel_i[0] && st_r == PDMM_IDLE;

    // storage port drive
    always_comb begin
        ram.we    = wr_lane0 && is_ram;
        ram.addr  = ram_addr;
        ram.wdata = dat_i[7:0];
    end

    // program fetch decode
    always_comb begin
        pmask = SMALL_PMASK;
        if (large_r) begin
            pmask = LARGE_PMASK;
        end
        pc_nxt = pc_r;
        if (irq_take_i) begin
            pc_nxt = INT_VEC;
        end else if (fetch_i) begin
            pc_nxt = pc_r + 13'h0001;
        end
        pma_nxt = pc_nxt & pmask;
    end

    // bus handshake and register next values
    always_comb begin
        st_nxt     = st_r;
        dat_nxt    = dat_r;
        ack_nxt    = 1'b0;
        rd_ram_nxt = rd_ram_r;
        status_nxt = status_r;
        ptr_nxt    = ptr_r;
        program_counter_high_holding_nxt = program_counter_high_holding_r;
        intctl_nxt = intctl_r;
        large_nxt  = large_r;
        case (st_r)
            PDMM_IDLE: begin
                if (cyc_i && stb_i) begin
                    dat_nxt    = {24'h000000, ZERO8};
                    rd_ram_nxt = is_ram;
                    case (off)
                        IDX_PCL[6:0]:    dat_nxt[7:0] = pc_r[7:0];
                        IDX_STATUS[6:0]: dat_nxt[7:0] = status_r;
                        IDX_POINTER[6:0]: dat_nxt[7:0] = ptr_r;
                        IDX_PROGRAM_COUNTER_HIGH_HOLDING[6:0]: dat_nxt[7:0] = program_counter_high_holding_r;
                        IDX_INTCTL[6:0]: dat_nxt[7:0] = intctl_r;
                        default:         dat_nxt[7:0] = ZERO8;
                    endcase
                    if (idx == IDX_CONFIG) begin
                        dat_nxt[7:0] = {7'h00, large_r};
                    end else if (idx == IDX_FETCH) begin
                        dat_nxt[12:0] = pma_r;
                        dat_nxt[7:0]  = pma_r[7:0];
                    end
                    if (wr_lane0) begin
                        if (idx == IDX_CONFIG) begin
                            large_nxt = dat_i[0];
                        end else if (idx != IDX_FETCH) begin
                            case (off)
                                IDX_STATUS[6:0]:  status_nxt = dat_i[7:0];
                                IDX_POINTER[6:0]: ptr_nxt    = dat_i[7:0];
                                IDX_PROGRAM_COUNTER_HIGH_HOLDING[6:0]:  program_counter_high_holding_nxt = dat_i[7:0];
                                IDX_INTCTL[6:0]:  intctl_nxt = dat_i[7:0];
                                default:          ;
                            endcase
                        end
                    end
                    if (we_i) begin
                        st_nxt  = PDMM_ACK;
                        ack_nxt = 1'b1;
                    end else begin
                        st_nxt = PDMM_READ;
                    end
                end
            end
            PDMM_READ: begin
                if (rd_ram_r) begin
                    dat_nxt = {24'h000000, ram.rdata};
                end
                ack_nxt = 1'b1;
                st_nxt  = PDMM_ACK;
            end
            PDMM_ACK: begin
                st_nxt = PDMM_IDLE;
            end
            default: st_nxt = PDMM_IDLE;
        endcase
    end

    // register update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r     <= PDMM_IDLE;
            dat_r    <= 32'h00000000;
            ack_r    <= 1'b0;
            pc_r     <= RESET_VEC;
            pma_r    <= RESET_VEC;
            status_r <= STATUS_RST;
            ptr_r    <= ZERO8;
            program_counter_high_holding_r <= ZERO8;
            intctl_r <= ZERO8;
            large_r  <= 1'b0;
            rd_ram_r <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            dat_r    <= dat_nxt;
            ack_r    <= ack_nxt;
            pc_r     <= pc_nxt;
            pma_r    <= pma_nxt;
            status_r <= status_nxt;
            ptr_r    <= ptr_nxt;
            program_counter_high_holding_r <= program_counter_high_holding_nxt;
            intctl_r <= intctl_nxt;
            large_r  <= large_nxt;
            rd_ram_r <= rd_ram_nxt;
        end
    end

    // outputs straight from flops
    assign dat_o       = dat_r;
    assign ack_o       = ack_r;
    assign pc_o        = pc_r;
    assign pmem_addr_o = pma_r;
    assign bank_o      = status_r[ST_BANK];
endmodule

// >>> pdmm_pkg.sv
// Function
// - thirteen bit counter spans 8K program words
// - small variant implements words 0000h to 03FFh
// - large variant implements words 0000h to 07FFh
// - addresses above implemented range wrap around
// - reset vector 0000h, interrupt vector 0004h
// - two banks, first 32 locations special
// - small variant storage at bank0 40h-7Fh
// - large variant storage 20h-7Fh and A0h-EFh
// - bank1 F0h-FFh mirrors bank0 70h-7Fh
// - unimplemented locations read zero, ignore writes
// - bank select bit picks direct bank
// - storage 64 or 128 bytes, direct or pointer
// - special registers other than PCL hold until written or reset
package pdmm_pkg;
    localparam int          PC_W          = 13;
    localparam int          RAM_AW        = 7;
    localparam int          RAM_DEPTH     = 128;
    localparam logic [12:0] RESET_VEC     = 13'h0000;
    localparam logic [12:0] INT_VEC       = 13'h0004;
    localparam logic [12:0] SMALL_PMASK   = 13'h03ff;
    localparam logic [12:0] LARGE_PMASK   = 13'h07ff;
    // wishbone word indices (byte address = 4 * index)
    localparam logic [7:0]  IDX_INDIRECT  = 8'h00;
    localparam logic [7:0]  IDX_PCL       = 8'h02;
    localparam logic [7:0]  IDX_STATUS    = 8'h03;
    localparam logic [7:0]  IDX_POINTER   = 8'h04;
    localparam logic [7:0]  IDX_PROGRAM_COUNTER_HIGH_HOLDING    = 8'h0a;
    localparam logic [7:0]  IDX_INTCTL    = 8'h0b;
    localparam logic [7:0]  IDX_CONFIG    = 8'h40;
    localparam logic [7:0]  IDX_FETCH     = 8'h41;
    // status bit positions
    localparam int          ST_BANK       = 5;
    localparam int          ST_UPPER      = 6;
    localparam int          ST_IND        = 7;
    // data map boundaries
    localparam logic [6:0]  SFR_TOP       = 7'h1f;
    localparam logic [6:0]  SMALL_GP_LO   = 7'h40;
    localparam logic [6:0]  LARGE_B1_HI   = 7'h6f;
    localparam logic [6:0]  COMMON_LO     = 7'h70;
    localparam logic [7:0]  STATUS_RST    = 8'h18;
    localparam logic [7:0]  ZERO8         = 8'h00;
endpackage

// >>> pdmm_ram_if.sv
`timescale 1ns/100ps
interface pdmm_ram_if;
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output we, output addr, output wdata, input rdata);
    modport slave  (input we, input addr, input wdata, output rdata);
endinterface

// >>> pdmm_ram.sv
`timescale 1ns/100ps
module pdmm_ram
    import pdmm_pkg::*;
(
    input  wire logic  clk_i,
    pdmm_ram_if.slave  port
);
    logic [7:0] mem [RAM_DEPTH];
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;

    // read data next value
    always_comb begin
        rd_nxt = mem[port.addr];
    end

    // storage write and registered read
    always_ff @(posedge clk_i) begin
        if (port.we) begin
            mem[port.addr] <= port.wdata;
        end
        rd_r <= rd_nxt;
    end

    assign port.rdata = rd_r;
endmodule

// >>> pdmm_checker.sv
`timescale 1ns/100ps
module pdmm_checker
    import pdmm_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // core side
    input wire logic        fetch_i,
    input wire logic        irq_take_i,
    input wire logic [12:0] pc_o,
    input wire logic [12:0] pmem_addr_o,
    input wire logic        bank_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // new bus requests
    sequence s_wr; $rose(cyc_i && stb_i) && we_i; endsequence
    sequence s_rd; $rose(cyc_i && stb_i) && !we_i; endsequence
    property p_rst_vec; $fell(rst_i) |-> pc_o == RESET_VEC && !bank_o; endproperty
    property p_irq; irq_take_i |=> pc_o == INT_VEC; endproperty
    property p_inc; fetch_i && !irq_take_i |=> pc_o == $past(pc_o) + 13'h1; endproperty
    property p_hold; !fetch_i && !irq_take_i |=> $stable(pc_o); endproperty
    property p_pmem; pmem_addr_o[12:11] == 2'b00; endproperty
    property p_wr; s_wr |=> ack_o ##1 !ack_o; endproperty
    property p_rd;
        s_rd |=> !ack_o ##1 (ack_o && dat_o[31:13] == 19'h0
                             && (dat_o[12:8] == 5'h0 || adr_i[9:2] == IDX_FETCH));
    endproperty
    property p_bank; $changed(bank_o) |-> $past(cyc_i && we_i) || $past(cyc_i && we_i, 2);
    endproperty
    a_rst_vec: assert property (p_rst_vec) else $error("pc or bank not cleared");
    a_irq: assert property (p_irq) else $error("interrupt vector wrong");
    a_inc: assert property (p_inc) else $error("pc did not advance");
    a_hold: assert property (p_hold) else $error("pc moved while idle");
    a_pmem: assert property (p_pmem) else $error("program address not wrapped");
    a_wr: assert property (p_wr) else $error("write answer wrong");
    a_rd: assert property (p_rd) else $error("read answer wrong");
    a_bank: assert property (p_bank) else $error("bank moved without write");
endmodule

bind pdmm_top pdmm_checker u_chk (.*);

// >>> pdmm_core_model.sv
`timescale 1ns/100ps
module pdmm_core_model (
    // clock
    input  wire logic clk_i,
    // program requests
    output logic      fetch_o,
    output logic      irq_take_o
);
    // idle core
    initial begin
        fetch_o = 1'b0;
        irq_take_o = 1'b0;
    end
    // fetch n words back to back
    task automatic run(input int n);
        fetch_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        fetch_o <= 1'b0;
    endtask
    // take one interrupt
    task automatic irq();
        irq_take_o <= 1'b1;
        @(posedge clk_i);
        irq_take_o <= 1'b0;
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import pdmm_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [31:0] adr_i = 0, dat_i = 0, dat_o;
    logic [3:0]  sel_i = 4'hf;
    logic        ack_o, fetch_i, irq_take_i, bank_o;
    logic [12:0] pc_o, pmem_addr_o;
    int          failures = 0, n_compared = 0;
    // clock
    always #5 clk_i = ~clk_i;
    pdmm_top DUT (.*);
    pdmm_core_model core (.clk_i(clk_i), .fetch_o(fetch_i), .irq_take_o(irq_take_i));
    // compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic wishbone cycle
    task automatic wb(input logic w, input logic [7:0] i, d, output logic [7:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {22'h0, i, 2'b00};
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] i, d);
        logic [7:0] q;
        wb(1'b1, i, d, q);
    endtask
    task automatic rd(input logic [7:0] i, e);
        logic [7:0] q;
        wb(1'b0, i, 8'h00, q);
        chk({8'h0, q}, {8'h0, e});
    endtask
    // state right after reset
    task automatic t_reset();
        chk({3'h0, pc_o}, 16'h0000);
        chk({15'h0, bank_o}, 16'h0000);
        rd(IDX_STATUS, STATUS_RST);
    endtask
    // vector, then run to 040Ah, past the small variant top
    task automatic t_prog(input logic big, input logic [12:0] exp);
        wr(IDX_CONFIG, {7'h0, big});
        core.irq();
        @(posedge clk_i);
        chk({3'h0, pc_o}, {3'h0, INT_VEC});
        core.run(1030);
        repeat (2) @(posedge clk_i);
        chk({3'h0, pc_o}, 16'h040a);
        chk({3'h0, pmem_addr_o}, {3'h0, exp});
        rd(IDX_FETCH, exp[7:0]);
    endtask
    // data map on the small variant
    task automatic t_small();
        wr(IDX_CONFIG, 8'h00);
        wr(8'h70, 8'ha5);
        rd(8'hf0, 8'ha5);
        wr(8'h20, 8'h3c);
        rd(8'h20, 8'h00);
        wr(8'ha0, 8'h5a);
        rd(8'ha0, 8'h00);
        rd(8'h05, 8'h00);
        wr(IDX_POINTER, 8'h7f);
        wr(IDX_INDIRECT, 8'h99);
        rd(8'h7f, 8'h99);
        rd(8'h84, 8'h7f);
        wr(IDX_STATUS, 8'h38);
        @(posedge clk_i);
        chk({15'h0, bank_o}, 16'h0001);
        rd(8'h83, 8'h38);
        rd(8'hf0, 8'ha5);
        rd(IDX_POINTER, 8'h7f);
        wr(IDX_STATUS, 8'h18);
        @(posedge clk_i);
        chk({15'h0, bank_o}, 16'h0000);
    endtask
    // data map on the large variant
    task automatic t_large();
        wr(IDX_CONFIG, 8'h01);
        wr(8'h20, 8'h3c);
        rd(8'h20, 8'h3c);
        wr(IDX_STATUS, 8'h38);
        wr(8'ha0, 8'h5a);
        rd(8'ha0, 8'h5a);
        rd(8'hf0, 8'ha5);
        wr(IDX_STATUS, 8'h18);
        rd(8'h20, 8'h3c);
    endtask
    // verdict
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_prog(1'b0, 13'h000a);
        t_prog(1'b1, 13'h040a);
        t_small();
        t_large();
        end_sim();
    end
    // watchdog
    initial begin
        #100us;
        failures++;
        end_sim();
    end
endmodule
